//--- common/loop_ref_profile_pkg.sv
// holds register indices, field positions, reset values and the profile carrier type
// assumes an APB master that places each register in one aligned 32-bit word
package loop_ref_profile_pkg;

    // register indices; byte address is four times the index
    localparam logic [13:0] IDX_REF_PRIORITY_ENABLE       = 14'h044d;
    localparam logic [13:0] IDX_LOOP_BW_SCALE_LOW         = 14'h044e;
    localparam logic [13:0] IDX_LOOP_BW_SCALE_MID         = 14'h044f;
    localparam logic [13:0] IDX_LOOP_BW_SCALE_HIGH_FILTER = 14'h0450;
    localparam logic [13:0] IDX_INT_FEEDBACK_DIV_LOW      = 14'h0451;
    localparam logic [13:0] IDX_INT_FEEDBACK_DIV_MID      = 14'h0452;
    localparam logic [13:0] IDX_INT_FEEDBACK_DIV_HIGH     = 14'h0453;
    localparam logic [13:0] IDX_FRAC_NUMERATOR_LOW        = 14'h0454;
    localparam logic [13:0] IDX_FRAC_NUMERATOR_MID        = 14'h0455;
    localparam logic [13:0] IDX_FRAC_NUMERATOR_HIGH       = 14'h0456;
    localparam logic [13:0] IDX_FRAC_MODULUS_LOW          = 14'h0457;
    localparam logic [13:0] IDX_FRAC_MODULUS_MID          = 14'h0458;
    localparam logic [13:0] IDX_FRAC_MODULUS_HIGH         = 14'h0459;

    // number of byte registers in the bank
    localparam int          REG_COUNT = 13;

    // slot of each register inside the bank (index minus bank base)
    localparam logic [3:0]  SLOT_PRIO      = 4'h0;
    localparam logic [3:0]  SLOT_BW_LOW    = 4'h1;
    localparam logic [3:0]  SLOT_BW_MID    = 4'h2;
    localparam logic [3:0]  SLOT_BW_HIGH   = 4'h3;
    localparam logic [3:0]  SLOT_DIV_LOW   = 4'h4;
    localparam logic [3:0]  SLOT_DIV_MID   = 4'h5;
    localparam logic [3:0]  SLOT_DIV_HIGH  = 4'h6;
    localparam logic [3:0]  SLOT_NUM_LOW   = 4'h7;
    localparam logic [3:0]  SLOT_NUM_MID   = 4'h8;
    localparam logic [3:0]  SLOT_NUM_HIGH  = 4'h9;
    localparam logic [3:0]  SLOT_MOD_LOW   = 4'ha;
    localparam logic [3:0]  SLOT_MOD_MID   = 4'hb;
    localparam logic [3:0]  SLOT_MOD_HIGH  = 4'hc;

    // field positions
    localparam int          ENABLE_BIT     = 0;
    localparam int          PRIO_LSB       = 1;
    localparam int          PRIO_MSB       = 2;
    localparam int          BW_BIT16_POS   = 0;
    localparam int          FILTER_BIT     = 1;

    // value after reset of every register
    localparam logic [7:0]  REG_RESET      = 8'h00;

    // writable bits per slot; reserved bits are held at zero
    localparam logic [REG_COUNT-1:0][7:0] WR_MASK = {
        8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
        8'h03, 8'hff, 8'hff, 8'h03, 8'hff, 8'hff, 8'h07};

    // profile handed to the first digital loop datapath
    typedef struct packed {
        logic        ref_enable;       // loop may lock to the second reference input
        logic [1:0]  ref_priority;     // 0 highest .. 3 lowest
        logic [16:0] bw_scale;         // loop bandwidth, 0.1 Hz steps
        logic        high_pm_filter;   // 1 = high phase margin base filter
        logic [17:0] int_div_m1;       // integer feedback count minus one
        logic [23:0] frac_num;         // fraction numerator
        logic [23:0] frac_den;         // fraction denominator
        logic        frac_bypass;      // fractional divider disabled and bypassed
    } loop_profile_t;

endpackage

//--- src/loop_ref_profile_regs.sv
// holds the second reference input profile bank of the first digital loop, on APB
// assumes one clock pclk, an APB master, and a loop datapath reading profile_r
//
// Function
// - bits 2:1 of priority register give priority level 0..3, reset 00
// - bit 0 of priority register enables locking to this reference, reset 0
// - 17-bit bandwidth factor in 0.1 Hz steps over three bytes, bit 16 at bit 0
// - bit 1 of third bandwidth byte selects high phase margin filter, reset 0
// - high margin filter at or below 2 kHz keeps peaking within 0.1 dB
// - 18-bit integer divider minus one over two bytes plus low two bits
// - 24-bit fraction numerator over three bytes, low byte first, reset zero
// - 24-bit fraction denominator over three bytes, low byte first, reset zero
// - after reset the three bandwidth bytes, filter bit included, read zero
// - zero denominator disables and bypasses the fractional divider
`timescale 1ns/1ps
`default_nettype none

module loop_ref_profile_regs (
    input  wire logic                                pclk,       // apb clock, 20 MHz
    input  wire logic                                presetn,    // async reset, active low
    input  wire logic                                psel,       // apb select
    input  wire logic                                penable,    // apb access phase
    input  wire logic                                pwrite,     // apb direction, 1 = write
    input  wire logic [15:0]                         paddr,      // apb byte address
    input  wire logic [31:0]                         pwdata,     // apb write data
    input  wire logic [3:0]                          pstrb,      // apb byte strobes
    output logic      [31:0]                         prdata,     // apb read data
    output logic                                     pready,     // apb ready
    output logic                                     pslverr,    // apb error, unmapped
    output loop_ref_profile_pkg::loop_profile_t      profile     // profile for the loop
);

    // register storage and bus state
    logic [7:0]                                 reg_r [loop_ref_profile_pkg::REG_COUNT];
    logic                                       pready_r;
    logic [31:0]                                prdata_r;
    logic                                       pslverr_r;
    loop_ref_profile_pkg::loop_profile_t        profile_r;
    loop_ref_profile_pkg::loop_profile_t        profile_nxt;

    // address decode terms
    logic [13:0]                                word_idx;
    logic [13:0]                                slot_wide;
    logic [3:0]                                 slot;
    logic                                       hit;
    logic                                       access_req;
    logic                                       wr_fire;
    logic [7:0]                                 rd_byte;

    // word index and bank slot of the current address
    assign word_idx   = paddr[15:2];
    assign slot_wide  = word_idx - loop_ref_profile_pkg::IDX_REF_PRIORITY_ENABLE;
    assign slot       = slot_wide[3:0];
    assign access_req = psel && penable;
    assign wr_fire    = access_req && pready_r && pwrite;

    // mapped only for aligned words inside the bank
    always_comb begin
        if (paddr[1:0] != 2'h0) begin
            hit = 1'b0;
        end else if (word_idx < loop_ref_profile_pkg::IDX_REF_PRIORITY_ENABLE) begin
            hit = 1'b0;
        end else if (word_idx > loop_ref_profile_pkg::IDX_FRAC_MODULUS_HIGH) begin
            hit = 1'b0;
        end else begin
            hit = 1'b1;
        end
    end

    // read mux; unmapped slots give zero
    always_comb begin
        rd_byte = 8'h00;
        if (hit) begin
            rd_byte = reg_r[slot];
        end
    end

    // one wait state: ready rises in the second access cycle, then drops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
        end else begin
            pready_r <= access_req && !pready_r;
        end
    end

    // read data and error are loaded at the same edge that raises ready
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r  <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end else if (access_req && !pready_r) begin
            prdata_r  <= (hit && !pwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
            pslverr_r <= !hit;
        end else begin
            prdata_r  <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end
    end

    // byte registers; write lands at the edge that completes the transfer
    generate
        for (genvar g = 0; g < loop_ref_profile_pkg::REG_COUNT; g++) begin : g_reg
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    reg_r[g] <= loop_ref_profile_pkg::REG_RESET;
                end else if (wr_fire && hit && (slot == 4'(g)) && pstrb[0]) begin
                    reg_r[g] <= pwdata[7:0] & loop_ref_profile_pkg::WR_MASK[g];
                end
            end
        end
    endgenerate

    // assemble the profile from the byte registers
    always_comb begin
        profile_nxt = '0;
        profile_nxt.ref_enable = reg_r[loop_ref_profile_pkg::SLOT_PRIO]
                                 [loop_ref_profile_pkg::ENABLE_BIT];
        profile_nxt.ref_priority = reg_r[loop_ref_profile_pkg::SLOT_PRIO]
                                   [loop_ref_profile_pkg::PRIO_MSB:
                                    loop_ref_profile_pkg::PRIO_LSB];
        profile_nxt.bw_scale = {reg_r[loop_ref_profile_pkg::SLOT_BW_HIGH]
                                [loop_ref_profile_pkg::BW_BIT16_POS],
                                reg_r[loop_ref_profile_pkg::SLOT_BW_MID],
                                reg_r[loop_ref_profile_pkg::SLOT_BW_LOW]};
        profile_nxt.high_pm_filter = reg_r[loop_ref_profile_pkg::SLOT_BW_HIGH]
                                     [loop_ref_profile_pkg::FILTER_BIT];
        profile_nxt.int_div_m1 = {reg_r[loop_ref_profile_pkg::SLOT_DIV_HIGH][1:0],
                                  reg_r[loop_ref_profile_pkg::SLOT_DIV_MID],
                                  reg_r[loop_ref_profile_pkg::SLOT_DIV_LOW]};
        profile_nxt.frac_num = {reg_r[loop_ref_profile_pkg::SLOT_NUM_HIGH],
                                reg_r[loop_ref_profile_pkg::SLOT_NUM_MID],
                                reg_r[loop_ref_profile_pkg::SLOT_NUM_LOW]};
        profile_nxt.frac_den = {reg_r[loop_ref_profile_pkg::SLOT_MOD_HIGH],
                                reg_r[loop_ref_profile_pkg::SLOT_MOD_MID],
                                reg_r[loop_ref_profile_pkg::SLOT_MOD_LOW]};
        // zero denominator: numerator withheld so only integer division acts
        profile_nxt.frac_bypass = (profile_nxt.frac_den == 24'h00_0000);
        if (profile_nxt.frac_bypass) begin
            profile_nxt.frac_num = 24'h00_0000;
        end
    end

    // profile output register, one cycle behind the byte registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            profile_r <= '0;
            profile_r.frac_bypass <= 1'b1;
        end else begin
            profile_r <= profile_nxt;
        end
    end

    // outputs straight from flip-flops
    assign prdata  = prdata_r;
    assign pready  = pready_r;
    assign pslverr = pslverr_r;
    assign profile = profile_r;

    // checks on the bank
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    logic rd_answer;
    assign rd_answer = access_req && !pready_r && !pwrite && hit;

    AST_PRIO_WRITE: assert property (
        (wr_fire && hit && slot == loop_ref_profile_pkg::SLOT_PRIO && pstrb[0])
        |-> ##2 (profile_r.ref_priority == $past(pwdata[2:1], 2)))
        else $error("priority level did not follow the written code");

    AST_ENABLE_WRITE: assert property (
        (wr_fire && hit && slot == loop_ref_profile_pkg::SLOT_PRIO && pstrb[0])
        |-> ##2 (profile_r.ref_enable == $past(pwdata[0], 2)))
        else $error("reference enable did not follow bit 0");

    AST_BW_BIT16: assert property (
        (wr_fire && hit && slot == loop_ref_profile_pkg::SLOT_BW_HIGH && pstrb[0])
        |-> ##2 (profile_r.bw_scale[16] == $past(pwdata[0], 2)))
        else $error("bandwidth bit 16 not taken from bit 0 of third byte");

    AST_BW_MID: assert property (
        (wr_fire && hit && slot == loop_ref_profile_pkg::SLOT_BW_MID && pstrb[0])
        |-> ##2 (profile_r.bw_scale[15:8] == $past(pwdata[7:0], 2)))
        else $error("bandwidth middle byte misplaced");

    AST_FILTER_SEL: assert property (
        (wr_fire && hit && slot == loop_ref_profile_pkg::SLOT_BW_HIGH && pstrb[0])
        |-> ##2 (profile_r.high_pm_filter == $past(pwdata[1], 2)))
        else $error("filter select did not follow bit 1");

    AST_DIV_HIGH: assert property (
        (wr_fire && hit && slot == loop_ref_profile_pkg::SLOT_DIV_HIGH && pstrb[0])
        |-> ##2 (profile_r.int_div_m1[17:16] == $past(pwdata[1:0], 2)))
        else $error("integer divider top bits misplaced");

    AST_NUM_HIGH: assert property (
        (wr_fire && hit && slot == loop_ref_profile_pkg::SLOT_NUM_HIGH && pstrb[0])
        ##1 (profile_nxt.frac_den != 24'h00_0000)
        |-> ##1 (profile_r.frac_num[23:16] == $past(pwdata[7:0], 2)))
        else $error("numerator top byte misplaced");

    AST_DEN_LOW: assert property (
        (wr_fire && hit && slot == loop_ref_profile_pkg::SLOT_MOD_LOW && pstrb[0])
        |-> ##2 (profile_r.frac_den[7:0] == $past(pwdata[7:0], 2)))
        else $error("denominator low byte misplaced");

    AST_BYPASS_ZERO: assert property (
        profile_r.frac_bypass == (profile_r.frac_den == 24'h00_0000)
        && (!profile_r.frac_bypass || profile_r.frac_num == 24'h00_0000))
        else $error("fractional bypass does not match zero denominator");

    AST_RESERVED_ZERO: assert property (
        (rd_answer && slot == loop_ref_profile_pkg::SLOT_BW_HIGH)
        |=> (prdata_r[31:2] == 30'h0000_0000) && pready_r)
        else $error("reserved bits of the filter byte read nonzero");

    AST_RESET_BW_ZERO: assert property (
        $rose(presetn) |-> (profile_r.bw_scale == 17'h0_0000) && !profile_r.high_pm_filter)
        else $error("bandwidth field not zero after reset");

    AST_READY_PULSE: assert property (
        access_req && !pready_r |=> pready_r ##1 !pready_r)
        else $error("ready not a single cycle after one wait state");

    AST_UNMAPPED_ERR: assert property (
        (access_req && !pready_r && !hit) |=> pslverr_r && pready_r)
        else $error("unmapped access not answered with error");

    COV_HIGH_PM: cover property (
        wr_fire && hit && slot == loop_ref_profile_pkg::SLOT_BW_HIGH && pwdata[1]);
    COV_DEN_READ: cover property (
        rd_answer && slot == loop_ref_profile_pkg::SLOT_MOD_HIGH);
    COV_FRAC_ON: cover property ($fell(profile_r.frac_bypass));
    COV_SLVERR: cover property (pslverr_r && pready_r);

endmodule // loop_ref_profile_regs

`default_nettype wire

//--- verification/tb_top.sv
// self-checking bench for the second reference profile register bank
// assumes the apb slave answers with one wait state and the profile lags by two edges
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin miscompares++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, got, exp); end end

module tb_top;
    typedef struct packed {
        logic [13:0] idx;
        logic [7:0]  wd;
        logic [7:0]  rd;
    } row_t;

    logic                               pclk;
    logic                               presetn;
    logic                               psel;
    logic                               penable;
    logic                               pwrite;
    logic [15:0]                        paddr;
    logic [31:0]                        pwdata;
    logic [3:0]                         pstrb;
    logic [31:0]                        prdata;
    logic                               pready;
    logic                               pslverr;
    loop_ref_profile_pkg::loop_profile_t profile;
    loop_ref_profile_pkg::loop_profile_t exp_prof;
    int                                 miscompares = 0;
    int                                 num_checks = 0;
    int                                 cycles = 0;
    logic [31:0]                        rd;
    logic                               err;
    row_t                               rows [9];

    loop_ref_profile_regs loop_ref_profile_regs_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .profile(profile));

    // free-running clock, 50 ns period
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    // cuts a hang short
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            miscompares++;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // one apb transfer, entered and left just after a rising edge
    task automatic apb(input logic w, input logic [13:0] idx, input logic [7:0] d,
                       input logic [3:0] st, output logic [31:0] q, output logic e,
                       input logic [1:0] lo = 2'b00);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= {idx, lo};
        pwdata  <= {24'h000000, d};
        pstrb   <= st;
        @(posedge pclk);
        penable <= 1'b1;
        // wait for the slave's answer; only the bench timeout ends a hang
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [13:0] idx, input logic [7:0] d);
        apb(1'b1, idx, d, 4'h1, rd, err);
    endtask

    initial begin
        presetn = 1'b0;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 16'h0000;
        pwdata  = 32'h00000000;
        pstrb   = 4'h0;
        rows = '{
            '{loop_ref_profile_pkg::IDX_REF_PRIORITY_ENABLE,       8'hff, 8'h07},
            '{loop_ref_profile_pkg::IDX_LOOP_BW_SCALE_LOW,         8'h34, 8'h34},
            '{loop_ref_profile_pkg::IDX_LOOP_BW_SCALE_MID,         8'h12, 8'h12},
            '{loop_ref_profile_pkg::IDX_LOOP_BW_SCALE_HIGH_FILTER, 8'hff, 8'h03},
            '{loop_ref_profile_pkg::IDX_INT_FEEDBACK_DIV_LOW,      8'ha5, 8'ha5},
            '{loop_ref_profile_pkg::IDX_INT_FEEDBACK_DIV_MID,      8'h5a, 8'h5a},
            '{loop_ref_profile_pkg::IDX_INT_FEEDBACK_DIV_HIGH,     8'hfe, 8'h02},
            '{loop_ref_profile_pkg::IDX_FRAC_NUMERATOR_LOW,        8'h11, 8'h11},
            '{loop_ref_profile_pkg::IDX_FRAC_NUMERATOR_HIGH,       8'h33, 8'h33}};
        exp_prof = '0;
        exp_prof.frac_bypass = 1'b1;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        // reset values of profile and of every register
        `CHK(profile, exp_prof)
        for (int i = 0; i < 13; i++) begin
            apb(1'b0, loop_ref_profile_pkg::IDX_REF_PRIORITY_ENABLE + 14'(i), 8'h00, 4'h0,
                rd, err);
            `CHK(rd, 32'h00000000)
        end
        // table: write each row, read it back through the reserved-bit mask
        foreach (rows[i]) begin
            wr(rows[i].idx, rows[i].wd);
            apb(1'b0, rows[i].idx, 8'h00, 4'h0, rd, err);
            `CHK(rd, {24'h000000, rows[i].rd})
        end
        @(posedge pclk);
        exp_prof.ref_enable     = 1'b1;
        exp_prof.ref_priority   = 2'h3;
        exp_prof.bw_scale       = 17'h11234;
        exp_prof.high_pm_filter = 1'b1;
        exp_prof.int_div_m1     = 18'h25aa5;
        `CHK(profile, exp_prof)
        // nonzero denominator ends the bypass and exposes the numerator
        wr(loop_ref_profile_pkg::IDX_FRAC_MODULUS_HIGH, 8'h80);
        @(posedge pclk);
        exp_prof.frac_den    = 24'h800000;
        exp_prof.frac_num    = 24'h330011;
        exp_prof.frac_bypass = 1'b0;
        `CHK(profile, exp_prof)
        // numerator and denominator bytes while the fraction is active
        wr(loop_ref_profile_pkg::IDX_FRAC_NUMERATOR_MID, 8'h22);
        wr(loop_ref_profile_pkg::IDX_FRAC_NUMERATOR_HIGH, 8'h44);
        wr(loop_ref_profile_pkg::IDX_FRAC_MODULUS_LOW, 8'h01);
        wr(loop_ref_profile_pkg::IDX_FRAC_MODULUS_MID, 8'h02);
        @(posedge pclk);
        exp_prof.frac_num    = 24'h442211;
        exp_prof.frac_den    = 24'h800201;
        `CHK(profile, exp_prof)
        // zero denominator brings the bypass back; the stored numerator still reads
        wr(loop_ref_profile_pkg::IDX_FRAC_MODULUS_LOW, 8'h00);
        wr(loop_ref_profile_pkg::IDX_FRAC_MODULUS_MID, 8'h00);
        wr(loop_ref_profile_pkg::IDX_FRAC_MODULUS_HIGH, 8'h00);
        @(posedge pclk);
        exp_prof.frac_num    = 24'h000000;
        exp_prof.frac_den    = 24'h000000;
        exp_prof.frac_bypass = 1'b1;
        `CHK(profile, exp_prof)
        apb(1'b0, loop_ref_profile_pkg::IDX_FRAC_NUMERATOR_HIGH, 8'h00, 4'h0, rd, err);
        `CHK(rd, 32'h00000044)
        // every priority code, enable cleared
        for (int p = 0; p < 4; p++) begin
            wr(loop_ref_profile_pkg::IDX_REF_PRIORITY_ENABLE, {5'h00, 2'(p), 1'b0});
            @(posedge pclk);
            `CHK(profile.ref_priority, 2'(p))
            `CHK(profile.ref_enable, 1'b0)
        end
        // write with byte strobe 0 is dropped
        apb(1'b1, loop_ref_profile_pkg::IDX_LOOP_BW_SCALE_LOW, 8'hee, 4'h0, rd, err);
        apb(1'b0, loop_ref_profile_pkg::IDX_LOOP_BW_SCALE_LOW, 8'h00, 4'h0, rd, err);
        `CHK(rd, 32'h00000034)
        // unmapped places answer with an error and read zero
        apb(1'b0, 14'h045a, 8'h00, 4'h0, rd, err);
        `CHK({err, rd}, {1'b1, 32'h00000000})
        apb(1'b1, 14'h044c, 8'hff, 4'h1, rd, err);
        `CHK(err, 1'b1)
        // misaligned byte addresses are refused and the write is dropped
        apb(1'b0, loop_ref_profile_pkg::IDX_LOOP_BW_SCALE_LOW, 8'h00, 4'h0, rd, err, 2'h2);
        `CHK({err, rd}, {1'b1, 32'h00000000})
        apb(1'b1, loop_ref_profile_pkg::IDX_LOOP_BW_SCALE_LOW, 8'h99, 4'h1, rd, err, 2'h1);
        apb(1'b0, loop_ref_profile_pkg::IDX_LOOP_BW_SCALE_LOW, 8'h00, 4'h0, rd, err);
        `CHK(rd, 32'h00000034)
        // reset in mid-run clears everything again
        presetn <= 1'b0;
        @(posedge pclk);
        exp_prof = '0;
        exp_prof.frac_bypass = 1'b1;
        `CHK(profile, exp_prof)
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, loop_ref_profile_pkg::IDX_LOOP_BW_SCALE_HIGH_FILTER, 8'h00, 4'h0, rd, err);
        `CHK(rd, 32'h00000000)
        report_and_stop();
    end
endmodule // tb_top

`default_nettype wire
